// ===== dual_watchdog_pkg.sv
// constants shared by the dual watchdog system
`default_nettype none
package dual_watchdog_pkg;

	////////////////////////////////////////////////////////////////////////
	// reference clock
	localparam int REF_CLK_HZ          = 25_000_000;
	localparam int REF_CLK_MHZ         = REF_CLK_HZ / 1_000_000;

	////////////////////////////////////////////////////////////////////////
	// windowed watchdog timing
	localparam int WIN_MIN_TIMEOUT_NS  = 75_000;
	localparam int WIN_MAX_TIMEOUT_NS  = 64_000_000;
	// one counter step equals the shortest timeout, rounded up to cycles
	localparam int WIN_TICK_CYCLES     =
		(WIN_MIN_TIMEOUT_NS * REF_CLK_MHZ + 999) / 1000;
	localparam int WIN_PRE_W           = 11;
	localparam int WIN_CNT_W           = 10;
	// timeout is (reload + 1) steps, longest rounded down
	localparam int WIN_MAX_STEPS       =
		WIN_MAX_TIMEOUT_NS / WIN_MIN_TIMEOUT_NS;
	localparam logic [WIN_CNT_W-1:0] WIN_MAX_RELOAD =
		WIN_CNT_W'(WIN_MAX_STEPS - 1);
	// window threshold out of reset: every refresh is in window
	localparam logic [WIN_CNT_W-1:0] WIN_WINDOW_RST = 10'h3ff;

	////////////////////////////////////////////////////////////////////////
	// independent watchdog timing, counted in oscillator periods
	localparam int LSI_HZ              = 128_000;
	localparam int LSI_KHZ             = LSI_HZ / 1000;
	localparam int IND_MIN_TIMEOUT_US  = 60;
	localparam int IND_MAX_TIMEOUT_US  = 1_000_000;
	localparam int IND_CNT_W           = 17;
	localparam logic [IND_CNT_W-1:0] IND_MIN_RELOAD =
		IND_CNT_W'((IND_MIN_TIMEOUT_US * LSI_KHZ + 999) / 1000);
	localparam logic [IND_CNT_W-1:0] IND_MAX_RELOAD =
		IND_CNT_W'((IND_MAX_TIMEOUT_US / 1000) * LSI_KHZ);

endpackage : dual_watchdog_pkg
`default_nettype wire

// ===== dual_watchdog_system.sv
// dual watchdog system: windowed and independent watchdogs, one reset out
//
// Overview of operation
// - two independent watchdogs, either one able to request a device reset.
// - each watchdog starts from its option bit at boot or a software start.
// - once active, no software write disables it; only reset clears it.
// - windowed watchdog resets on timeout; timeout spans 75 us to 64 ms.
// - refresh while counter is not yet below window threshold resets.
// - independent watchdog counts on the 128 kHz low speed oscillator.
// - independent watchdog timeout spans 60 us up to 1 s.
`default_nettype none
module dual_watchdog_system
	import dual_watchdog_pkg::*;
#(
	parameter int WIN_TICK = WIN_TICK_CYCLES
) (
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_win_opt_en,
	input  wire logic                 i_ind_opt_en,
	input  wire logic                 i_win_start,
	input  wire logic                 i_win_refresh,
	input  wire logic [WIN_CNT_W-1:0] i_win_reload,
	input  wire logic                 i_win_window_wr,
	input  wire logic [WIN_CNT_W-1:0] i_win_window,
	input  wire logic                 i_ind_start,
	input  wire logic                 i_ind_refresh,
	input  wire logic [IND_CNT_W-1:0] i_ind_reload,
	input  wire logic                 i_low_speed_internal_osc,
	output logic                      o_wdg_reset,
	output logic                      o_win_active,
	output logic                      o_ind_active,
	output logic [WIN_CNT_W-1:0]      o_win_count,
	output logic                      o_win_fired,
	output logic                      o_ind_fired
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [WIN_CNT_W-1:0] win_clamp(
		input logic [WIN_CNT_W-1:0] v
	);
		win_clamp = (v > WIN_MAX_RELOAD) ? WIN_MAX_RELOAD : v;
	endfunction : win_clamp

	function automatic logic [IND_CNT_W-1:0] ind_clamp(
		input logic [IND_CNT_W-1:0] v
	);
		if (v < IND_MIN_RELOAD)
			ind_clamp = IND_MIN_RELOAD;
		else if (v > IND_MAX_RELOAD)
			ind_clamp = IND_MAX_RELOAD;
		else
			ind_clamp = v;
	endfunction : ind_clamp

	localparam logic [WIN_PRE_W-1:0] WIN_PRE_LAST = WIN_PRE_W'(WIN_TICK - 1);

	logic                 boot_reg;
	logic                 win_active_reg;
	logic                 ind_active_reg;
	logic [WIN_PRE_W-1:0] win_pre_reg;
	logic [WIN_CNT_W-1:0] win_cnt_reg;
	logic [WIN_CNT_W-1:0] win_window_reg;
	logic [IND_CNT_W-1:0] ind_cnt_reg;
	logic                 lsi_meta_reg;
	logic                 lsi_sync_reg;
	logic                 lsi_prev_reg;
	logic                 win_fired_reg;
	logic                 ind_fired_reg;
	logic                 reset_reg;
	logic                 win_tick;
	logic                 win_early;
	logic                 win_fire;
	logic                 lsi_edge;
	logic                 ind_fire;

	////////////////////////////////////////////////////////////////////////
	// activation: option bits are taken in the first cycle after release

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			boot_reg <= 1'b0;
		else
			boot_reg <= 1'b1;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			win_active_reg <= 1'b0;
			ind_active_reg <= 1'b0;
		end else begin
			if ((!boot_reg && i_win_opt_en) || i_win_start)
				win_active_reg <= 1'b1;
			if ((!boot_reg && i_ind_opt_en) || i_ind_start)
				ind_active_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// windowed watchdog

	assign win_tick  = (win_pre_reg == WIN_PRE_LAST);
	// refresh too early
	// equal to the threshold is not yet below it, so it counts as early
	assign win_early = win_active_reg && i_win_refresh
		&& (win_cnt_reg >= win_window_reg);
	assign win_fire  = win_early || (win_active_reg && !i_win_refresh
		&& win_tick && (win_cnt_reg == '0));

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			win_window_reg <= WIN_WINDOW_RST;
		else if (i_win_window_wr)
			win_window_reg <= i_win_window;
	end

	// a refresh restarts the step divider so timeouts stay exact
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			win_pre_reg <= '0;
		else if (!win_active_reg || i_win_refresh || i_win_start || win_tick)
			win_pre_reg <= '0;
		else
			win_pre_reg <= win_pre_reg + 1'b1;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			win_cnt_reg <= WIN_MAX_RELOAD;
		else if (i_win_start || (win_active_reg && i_win_refresh))
			win_cnt_reg <= win_clamp(i_win_reload);
		else if (win_active_reg && win_tick && win_cnt_reg != '0)
			win_cnt_reg <= win_cnt_reg - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// independent watchdog
	// the oscillator is sampled, so the reference clock must keep running;
	// a real part would run this counter on the oscillator itself

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			lsi_meta_reg <= 1'b0;
			lsi_sync_reg <= 1'b0;
			lsi_prev_reg <= 1'b0;
		end else begin
			lsi_meta_reg <= i_low_speed_internal_osc;
			lsi_sync_reg <= lsi_meta_reg;
			lsi_prev_reg <= lsi_sync_reg;
		end
	end

	assign lsi_edge = lsi_sync_reg && !lsi_prev_reg;
	assign ind_fire = ind_active_reg && !i_ind_refresh && !i_ind_start
		&& lsi_edge && (ind_cnt_reg == IND_CNT_W'(1));

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			ind_cnt_reg <= IND_MAX_RELOAD;
		else if (i_ind_start || (ind_active_reg && i_ind_refresh))
			ind_cnt_reg <= ind_clamp(i_ind_reload);
		else if (ind_active_reg && lsi_edge && ind_cnt_reg > IND_CNT_W'(1))
			ind_cnt_reg <= ind_cnt_reg - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// reset request

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			win_fired_reg <= 1'b0;
			ind_fired_reg <= 1'b0;
			reset_reg     <= 1'b0;
		end else begin
			if (win_fire)
				win_fired_reg <= 1'b1;
			if (ind_fire)
				ind_fired_reg <= 1'b1;
			if (win_fire || ind_fire)
				reset_reg <= 1'b1;
		end
	end

	assign o_wdg_reset  = reset_reg;
	assign o_win_active = win_active_reg;
	assign o_ind_active = ind_active_reg;
	assign o_win_count  = win_cnt_reg;
	assign o_win_fired  = win_fired_reg;
	assign o_ind_fired  = ind_fired_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_win_stays_on: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		win_active_reg |=> win_active_reg)
		else $error("windowed watchdog left active state");

	a_ind_stays_on: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		ind_active_reg |=> ind_active_reg)
		else $error("independent watchdog left active state");

	a_boot_option: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(!boot_reg && i_win_opt_en && i_ind_opt_en)
		|=> (win_active_reg && ind_active_reg))
		else $error("option bits did not start watchdogs");

	a_sw_start_ind: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_ind_start |=> ind_active_reg)
		else $error("software start ignored");

	a_win_timeout: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(win_active_reg && win_cnt_reg == '0 && !i_win_refresh
		 && !i_win_start && win_tick) |=> (o_wdg_reset && o_win_fired))
		else $error("windowed timeout did not reset");

	a_win_range: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		win_active_reg |-> (win_cnt_reg <= WIN_MAX_RELOAD))
		else $error("windowed count beyond longest timeout");

	a_win_early: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(win_active_reg && i_win_refresh && win_cnt_reg >= win_window_reg)
		|=> o_win_fired)
		else $error("early refresh not punished");

	a_win_in_window: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(win_active_reg && !win_fired_reg && i_win_refresh && !i_win_start
		 && win_cnt_reg < win_window_reg && !ind_fire && !reset_reg)
		|=> !o_wdg_reset)
		else $error("in-window refresh caused reset");

	a_ind_fire: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(ind_active_reg && lsi_sync_reg && !lsi_prev_reg
		 && ind_cnt_reg == IND_CNT_W'(1) && !i_ind_refresh && !i_ind_start)
		|=> (o_ind_fired && o_wdg_reset))
		else $error("independent timeout did not reset");

	a_ind_range: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		ind_active_reg |-> (ind_cnt_reg >= IND_CNT_W'(1)
		&& ind_cnt_reg <= IND_MAX_RELOAD))
		else $error("independent count out of range");

	a_ind_isolated: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(!lsi_edge && !i_ind_refresh && !i_ind_start)
		|=> $stable(ind_cnt_reg))
		else $error("independent counter moved without its own cause");

	a_reset_hold: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(o_wdg_reset) |-> ($past(win_fire) || $past(ind_fire))
		##1 o_wdg_reset)
		else $error("reset out without cause or too short");

endmodule : dual_watchdog_system
`default_nettype wire

// ===== tb.sv
// self-checking testbench for the dual watchdog system
`default_nettype none
module tb;
	import dual_watchdog_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TICK = 4;
	logic                 ref_clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 win_opt = 1'b0;
	logic                 ind_opt = 1'b0;
	logic                 win_start = 1'b0;
	logic                 win_refresh = 1'b0;
	logic [WIN_CNT_W-1:0] win_reload = 10'h000;
	logic                 win_wr = 1'b0;
	logic [WIN_CNT_W-1:0] win_window = 10'h000;
	logic                 ind_start = 1'b0;
	logic                 ind_refresh = 1'b0;
	logic [IND_CNT_W-1:0] ind_reload = 17'h00000;
	logic                 osc = 1'b0;
	logic                 wdg_reset;
	logic                 win_active;
	logic                 ind_active;
	logic                 win_fired;
	logic                 ind_fired;
	logic [WIN_CNT_W-1:0] win_count;
	int                   num_errors = 0;
	int                   samples_checked = 0;

	always #20 ref_clk = ~ref_clk;

	dual_watchdog_system #(.WIN_TICK(TICK)) i_dut (
		.i_ref_clk(ref_clk), .i_rst_n(rst_n),
		.i_win_opt_en(win_opt), .i_ind_opt_en(ind_opt),
		.i_win_start(win_start), .i_win_refresh(win_refresh),
		.i_win_reload(win_reload), .i_win_window_wr(win_wr),
		.i_win_window(win_window), .i_ind_start(ind_start),
		.i_ind_refresh(ind_refresh), .i_ind_reload(ind_reload),
		.i_low_speed_internal_osc(osc), .o_wdg_reset(wdg_reset),
		.o_win_active(win_active), .o_ind_active(ind_active),
		.o_win_count(win_count), .o_win_fired(win_fired),
		.o_ind_fired(ind_fired));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	// strobe then one idle edge, so back-to-back calls never collide
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask : pulse

	task automatic do_reset(input logic wo, input logic io);
		@(negedge ref_clk);
		rst_n = 1'b0;
		win_opt = wo;
		ind_opt = io;
		cyc(10);
		check(win_count === WIN_MAX_RELOAD && wdg_reset === 1'b0,
			"reset state");
		check(win_fired === 1'b0 && ind_fired === 1'b0, "fired at reset");
		rst_n = 1'b1;
		cyc(2);
	endtask : do_reset

	task automatic osc_edges(input int n);
		repeat (n) begin
			cyc(8);
			osc = 1'b1;
			cyc(8);
			osc = 1'b0;
		end
	endtask : osc_edges

	////////////////////////////////////////////////////////////////////////
	task automatic t_timeout;
		do_reset(1'b0, 1'b0);
		check(win_active === 1'b0 && ind_active === 1'b0, "idle at boot");
		pulse(ind_refresh);
		check(ind_active === 1'b0, "refresh started watchdog");
		win_reload = 10'h001;
		pulse(win_start);
		check(win_count === 10'h001, "start did not load count");
		cyc(4);
		check(win_fired === 1'b0 && wdg_reset === 1'b0, "early timeout");
		cyc(5);
		check(win_fired === 1'b1 && wdg_reset === 1'b1, "no timeout");
		check(win_active === 1'b1, "active lost");
		$display("test timeout done");
	endtask : t_timeout

	task automatic t_window;
		do_reset(1'b0, 1'b0);
		win_reload = 10'h002;
		pulse(win_start);
		win_window = 10'h005;
		pulse(win_wr);
		win_reload = 10'h00a;
		pulse(win_refresh);
		check(wdg_reset === 1'b0, "in-window refresh fired");
		check(win_count === 10'h00a, "refresh did not reload");
		pulse(win_refresh);
		check(win_fired === 1'b1 && wdg_reset === 1'b1, "early refresh");
		check(ind_fired === 1'b0, "wrong source flagged");
		$display("test window done");
	endtask : t_window

	task automatic t_option;
		do_reset(1'b1, 1'b1);
		win_opt = 1'b0;
		ind_opt = 1'b0;
		check(win_active === 1'b1 && ind_active === 1'b1, "option start");
		cyc(3390);
		check(win_fired === 1'b0, "long timeout too short");
		cyc(30);
		check(win_fired === 1'b1 && ind_fired === 1'b0, "long timeout");
		$display("test option done");
	endtask : t_option

	task automatic t_indep;
		do_reset(1'b1, 1'b0);
		ind_reload = 17'h00003;
		pulse(ind_start);
		check(ind_active === 1'b1, "ind start");
		osc_edges(7);
		check(ind_fired === 1'b0 && wdg_reset === 1'b0, "ind early");
		osc_edges(1);
		check(ind_fired === 1'b1 && wdg_reset === 1'b1, "ind timeout");
		check(win_fired === 1'b0, "win fired instead");
		$display("test independent done");
	endtask : t_indep

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	initial begin
		t_timeout();
		t_window();
		t_option();
		t_indep();
		summarize();
	end

	// whole run is about 4000 cycles; allow a wide margin
	initial begin
		#(40 * 20000);
		num_errors++;
		$display("ERROR %0t: watchdog timeout", $time);
		summarize();
	end

endmodule : tb
`default_nettype wire
